// ---- hdl/hpdc_regs.vh ----
`ifndef HPDC_REGS_VH
`define HPDC_REGS_VH

// Register offsets on the 5-bit register select lines
`define HPDC_OFF_CNT_FIRST   5'h00
`define HPDC_OFF_CNT_LAST    5'h0c
`define HPDC_OFF_MASK2       5'h10
`define HPDC_OFF_EVT_FLAGS   5'h11
`define HPDC_OFF_LATCH_MASK  5'h12
`define HPDC_OFF_LOWER_INFO  5'h1f

// Second event count mask fields
`define HPDC_M2_FCS          0
`define HPDC_M2_ALIGN        1
`define HPDC_M2_PART         2
`define HPDC_M2_OOWC         3
`define HPDC_M2_ROR          6
`define HPDC_M2_FWF          7

// Lower event information fields
`define HPDC_LI_INHIBIT      0

// Reset values and the full counter value
`define HPDC_RST_MASK2       8'h00
`define HPDC_RST_LATCH_MASK  8'h00
`define HPDC_RST_LOWER_INFO  8'h00
`define HPDC_CNT_FULL        8'hff

// Timing, 25 MHz core clock
`define HPDC_CLK_MHZ         25
`define HPDC_SLAVE_MAX_NS    400
`define HPDC_SLAVE_MAX_CYC   ((`HPDC_SLAVE_MAX_NS * `HPDC_CLK_MHZ) / 1000)
`define HPDC_ACC_NS          160
`define HPDC_ACC_CYC         ((`HPDC_ACC_NS * `HPDC_CLK_MHZ) / 1000)
`define HPDC_DISP_NS         200
`define HPDC_DISP_CYC        ((`HPDC_DISP_NS * `HPDC_CLK_MHZ) / 1000)
`define HPDC_DISP_STB_CYC    2

`endif

// ---- hdl/hpdc_ctr_bank.v ----
`timescale 1ns/1ns
`include "hpdc_regs.vh"

module hpdc_ctr_bank (
   // Clock and reset
   input  wire          clk,
   input  wire          rst,
   input  wire          ce,
   // Event selection and control
   input  wire [3:0]    sel,
   input  wire          freeze,
   input  wire [12:0]   clr,
   // Per-port events
   input  wire [12:0]   evt_fcs,
   input  wire [12:0]   evt_align,
   input  wire [12:0]   evt_part,
   input  wire [12:0]   evt_oowc,
   // Counter values, port 0 in the low byte
   output wire [103:0]  cnt
);

   genvar i;
   generate
      for (i = 0; i < 13; i = i + 1) begin : g_ctr
         reg  [7:0] cnt_q;
         wire       inc;
         assign inc = |(sel & {evt_oowc[i], evt_part[i], evt_align[i], evt_fcs[i]});
         always @(posedge clk) begin
            if (rst) begin
               cnt_q <= 8'h00;
            end else if (ce) begin
               // An event in the clearing cycle is still counted
               if (clr[i]) begin
                  cnt_q <= inc ? 8'h01 : 8'h00;
               end else if (inc && !(freeze && cnt_q == `HPDC_CNT_FULL)) begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
         end
         assign cnt[i*8 +: 8] = cnt_q;
      end
   endgenerate

endmodule

// ---- hdl/hpdc_host_port.v ----
`timescale 1ns/1ns
`include "hpdc_regs.vh"

module hpdc_host_port (
   // Clock and reset
   input  wire          CORE_CLK,
   input  wire          RST,
   input  wire          CLK_EN,
   // Host register access
   input  wire          CS_N,
   input  wire          RD_N,
   input  wire          WR_N,
   input  wire [4:0]    REGISTER_SELECT_LINES,
   input  wire [7:0]    DATA_IN,
   output wire [7:0]    DATA_OUT,
   output wire          DATA_OE,
   output wire          RDY,
   // External data buffer
   output wire          BUF_EN_N,
   output wire          BUF_DIR_RD,
   // Display latches
   input  wire [15:0]   LED_STATUS,
   output wire          DISP_LATCH_SEL,
   output wire          DISP_STROBE,
   // Management events, one bit per port
   input  wire [12:0]   EVT_FCS,
   input  wire [12:0]   EVT_ALIGN,
   input  wire [12:0]   EVT_PART,
   input  wire [12:0]   EVT_OOWC,
   // Management status append
   input  wire          MGT_PKT_END,
   output wire [7:0]    MGT_STATUS,
   output wire          MGT_STATUS_VALID
);

   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_DISP = 4'h2;
   localparam [3:0] ST_ACC  = 4'h4;
   localparam [3:0] ST_DONE = 4'h8;

   // Counts worked out as integers, then cut to the timer width
   localparam integer ACC_CYC_I  = `HPDC_ACC_CYC;
   localparam integer DISP_CYC_I = `HPDC_DISP_CYC;
   localparam integer STB_CYC_I  = `HPDC_DISP_STB_CYC;
   localparam [3:0]   ACC_CYC    = ACC_CYC_I[3:0];
   localparam [3:0]   DISP_CYC   = DISP_CYC_I[3:0];
   localparam [3:0]   STB_CYC    = STB_CYC_I[3:0];

   // Does the select address one of the counters
   function is_cnt;
      input [4:0] a;
      begin
         is_cnt = ((a - `HPDC_OFF_CNT_FIRST) <= (`HPDC_OFF_CNT_LAST - `HPDC_OFF_CNT_FIRST));
      end
   endfunction

   // One-hot counter select for an address
   function [12:0] cnt_hot;
      input [4:0] a;
      begin
         cnt_hot = is_cnt(a) ? (13'h0001 << a[3:0]) : 13'h0000;
      end
   endfunction

   reg  [3:0]   state_q;
   reg  [3:0]   state_d;
   reg  [3:0]   tmr_q;
   reg  [3:0]   tmr_d;
   reg          rd_q;
   reg          rd_d;
   reg  [4:0]   addr_q;
   reg  [4:0]   addr_d;
   reg  [7:0]   dout_q;
   reg  [7:0]   dout_d;
   reg          disp_sel_q;
   reg  [7:0]   mask2_q;
   reg  [7:0]   latch_mask_q;
   reg  [7:0]   lower_info_q;
   reg  [3:0]   flags_q;
   reg  [3:0]   pkt_flags_q;
   reg  [7:0]   mgt_status_q;
   reg          mgt_valid_q;
   reg  [7:0]   rdata;
   wire         req;
   wire         inhibit;
   wire         enter_done;
   wire         wr_done;
   wire         rd_done;
   wire [3:0]   evt_any;
   wire [12:0]  cnt_clr;
   wire [103:0] cnt_all;

   // A request needs the select and one strobe
   assign req     = !CS_N && (!RD_N || !WR_N);
   assign inhibit = lower_info_q[`HPDC_LI_INHIBIT];
   assign evt_any = {|EVT_OOWC, |EVT_PART, |EVT_ALIGN, |EVT_FCS};

   // Last access cycle; writes and read side effects land on its edge
   assign enter_done = (state_q == ST_ACC) && (tmr_q == 4'h1);
   assign wr_done    = enter_done && !rd_q;
   assign rd_done    = enter_done && rd_q;

   // Arbiter between display cycles and host accesses
   always @* begin
      state_d = state_q;
      tmr_d   = tmr_q;
      rd_d    = rd_q;
      addr_d  = addr_q;
      case (state_q)
         ST_IDLE: begin
            if (req) begin
               state_d = ST_ACC;
               tmr_d   = ACC_CYC;
               rd_d    = !RD_N;
               addr_d  = REGISTER_SELECT_LINES;
            end else if (!inhibit) begin
               state_d = ST_DISP;
               tmr_d   = DISP_CYC;
            end
         end
         ST_DISP: begin
            // A started display cycle always finishes so the latch sees good data
            if (tmr_q == 4'h1) begin
               state_d = ST_IDLE;
            end else begin
               tmr_d = tmr_q - 4'h1;
            end
         end
         ST_ACC: begin
            if (tmr_q == 4'h1) begin
               state_d = ST_DONE;
            end else begin
               tmr_d = tmr_q - 4'h1;
            end
         end
         ST_DONE: begin
            if (!req) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         state_q <= ST_IDLE;
         tmr_q   <= 4'h0;
         rd_q    <= 1'b0;
         addr_q  <= 5'h00;
      end else if (CLK_EN) begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
         rd_q    <= rd_d;
         addr_q  <= addr_d;
      end
   end

   // Display latch alternates between two status bytes each cycle
   always @(posedge CORE_CLK) begin
      if (RST) begin
         disp_sel_q <= 1'b0;
      end else if (CLK_EN && state_q == ST_DISP && tmr_q == 4'h1) begin
         disp_sel_q <= ~disp_sel_q;
      end
   end

   // Register read data
   // Unmapped selects read as zero
   always @* begin
      rdata = 8'h00;
      if (is_cnt(addr_q)) begin
         rdata = cnt_all[addr_q[3:0]*8 +: 8];
      end else begin
         case (addr_q)
            `HPDC_OFF_MASK2:      rdata = mask2_q;
            `HPDC_OFF_EVT_FLAGS:  rdata = {4'h0, flags_q};
            `HPDC_OFF_LATCH_MASK: rdata = latch_mask_q;
            `HPDC_OFF_LOWER_INFO: rdata = lower_info_q;
            default:              rdata = 8'h00;
         endcase
      end
   end

   // Data pins carry read data during reads and display bytes during display cycles
   always @* begin
      dout_d = dout_q;
      if (state_d == ST_ACC && state_q == ST_IDLE) begin
         dout_d = 8'h00;
      end else if (state_q == ST_ACC && rd_q) begin
         dout_d = rdata;
      end else if (state_d == ST_DISP && state_q == ST_IDLE) begin
         dout_d = disp_sel_q ? LED_STATUS[15:8] : LED_STATUS[7:0];
      end
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         dout_q <= 8'h00;
      end else if (CLK_EN) begin
         dout_q <= dout_d;
      end
   end

   // Writable registers
   always @(posedge CORE_CLK) begin
      if (RST) begin
         mask2_q      <= `HPDC_RST_MASK2;
         latch_mask_q <= `HPDC_RST_LATCH_MASK;
         lower_info_q <= `HPDC_RST_LOWER_INFO;
      end else if (CLK_EN && wr_done) begin
         case (addr_q)
            `HPDC_OFF_MASK2:      mask2_q      <= DATA_IN;
            `HPDC_OFF_LATCH_MASK: latch_mask_q <= DATA_IN;
            `HPDC_OFF_LOWER_INFO: lower_info_q <= DATA_IN;
            // Counters and flags ignore writes
            default:              mask2_q      <= mask2_q;
         endcase
      end
   end

   // Sticky event latches, cleared by reading them; a new event wins
   always @(posedge CORE_CLK) begin
      if (RST) begin
         flags_q <= 4'h0;
      end else if (CLK_EN) begin
         if (rd_done && addr_q == `HPDC_OFF_EVT_FLAGS) begin
            flags_q <= evt_any & latch_mask_q[3:0];
         end else begin
            flags_q <= flags_q | (evt_any & latch_mask_q[3:0]);
         end
      end
   end

   // Per-packet status, presented once after the packet ends
   always @(posedge CORE_CLK) begin
      if (RST) begin
         pkt_flags_q  <= 4'h0;
         mgt_status_q <= 8'h00;
         mgt_valid_q  <= 1'b0;
      end else if (CLK_EN) begin
         mgt_valid_q <= MGT_PKT_END;
         // Events of the closing cycle belong to this packet
         if (MGT_PKT_END) begin
            mgt_status_q <= {4'h0, pkt_flags_q | evt_any};
            pkt_flags_q  <= 4'h0;
         end else begin
            pkt_flags_q <= pkt_flags_q | evt_any;
         end
      end
   end

   // Reset-on-read clears a counter as its read completes
   assign cnt_clr = (rd_done && mask2_q[`HPDC_M2_ROR]) ? cnt_hot(addr_q) : 13'h0000;

   // No decrement path and no interrupt output reach these counters
   hpdc_ctr_bank u_ctr (
      .clk       (CORE_CLK),
      .rst       (RST),
      .ce        (CLK_EN),
      .sel       (mask2_q[3:0]),
      .freeze    (mask2_q[`HPDC_M2_FWF]),
      .clr       (cnt_clr),
      .evt_fcs   (EVT_FCS),
      .evt_align (EVT_ALIGN),
      .evt_part  (EVT_PART),
      .evt_oowc  (EVT_OOWC),
      .cnt       (cnt_all)
   );

   // Bus and buffer control
   // Display cycles keep the external buffer closed
   assign DATA_OUT         = dout_q;
   assign DATA_OE          = (state_q == ST_DISP) || ((state_q == ST_ACC || state_q == ST_DONE) && rd_q);
   assign BUF_EN_N         = !(state_q == ST_ACC || state_q == ST_DONE);
   assign BUF_DIR_RD       = rd_q;
   assign RDY              = (state_q == ST_DONE);
   assign DISP_LATCH_SEL   = disp_sel_q;
   assign DISP_STROBE      = (state_q == ST_DISP) && (tmr_q <= STB_CYC) && (tmr_q > 4'h1);
   assign MGT_STATUS       = mgt_status_q;
   assign MGT_STATUS_VALID = mgt_valid_q;

endmodule

// ---- tb/hpdc_host_port_chk.sv ----
`timescale 1ns/1ns
module hpdc_chk (
   // Clock and reset
   input logic        CORE_CLK,
   input logic        RST,
   // Host access
   input logic        CS_N,
   input logic        RD_N,
   input logic        WR_N,
   input logic [7:0]  DATA_OUT,
   input logic        DATA_OE,
   input logic        RDY,
   input logic        BUF_EN_N,
   input logic        BUF_DIR_RD,
   // Display and status append
   input logic        DISP_LATCH_SEL,
   input logic        DISP_STROBE,
   input logic [12:0] EVT_FCS,
   input logic        MGT_PKT_END,
   input logic [7:0]  MGT_STATUS,
   input logic        MGT_STATUS_VALID
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence s_wait;
      !RDY [*4];
   endsequence
   sequence s_done;
      RDY && !BUF_EN_N;
   endsequence
   a_access_latency: assert property ($fell(BUF_EN_N) |-> s_wait ##1 s_done) else $error("bad latency");
   a_rdy_buffer: assert property (RDY |-> !BUF_EN_N) else $error("ready without buffer");
   a_read_drive: assert property ($fell(BUF_EN_N) && !RD_N |-> BUF_DIR_RD && DATA_OE) else $error("read dir");
   a_write_quiet: assert property (!BUF_EN_N && !BUF_DIR_RD |-> !DATA_OE) else $error("write drive");
   a_display_master: assert property (DISP_STROBE |-> BUF_EN_N && DATA_OE) else $error("display bus");
   a_strobe_alone: assert property (!BUF_EN_N |-> !DISP_STROBE) else $error("strobe in access");
   a_latch_advance: assert property (DISP_STROBE |=> !DISP_STROBE ##[0:5] $changed(DISP_LATCH_SEL))
      else $error("latch select");
   a_rdy_stands: assert property (RDY && !CS_N && !RD_N |=> RDY && $stable(DATA_OUT)) else $error("ready drop");
   a_rdy_release: assert property (RDY && CS_N && RD_N && WR_N |=> !RDY && BUF_EN_N) else $error("release");
   a_status_append: assert property (MGT_PKT_END && EVT_FCS != 13'h0 |=> MGT_STATUS_VALID && MGT_STATUS[0])
      else $error("status append");
endmodule

// ---- tb/hpdc_cpu.sv ----
`timescale 1ns/1ns
module hpdc_cpu (
   // Clock
   input  logic       clk,
   // Device side of the buffer
   input  logic       rdy,
   input  logic       buf_en_n,
   input  logic       buf_dir_rd,
   input  logic [7:0] data_out,
   output logic       cs_n,
   output logic       rd_n,
   output logic       wr_n,
   output logic [4:0] sel,
   output logic [7:0] data_in
);
   logic [7:0] wd_q;
   int         cyc;
   logic       tmo;
   // Buffer passes write data only when enabled; else the model drives the inverted write data
   assign data_in = (!buf_en_n && !buf_dir_rd) ? wd_q : ~wd_q;
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      sel = 5'h00;
      wd_q = 8'h00;
      tmo = 1'b0;
   end
   task xfer(input logic rd, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] q);
      cyc = 0;
      @(posedge clk);
      cs_n <= 1'b0;
      rd_n <= !rd;
      wr_n <= rd;
      sel <= a;
      wd_q <= wd;
      do begin
         @(posedge clk);
         cyc++;
      end while (rdy !== 1'b1 && cyc < 20);
      q = data_out;
      tmo = (rdy !== 1'b1);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      @(posedge clk);
   endtask
endmodule

// ---- tb/test_host_port_display_counters.sv ----
`timescale 1ns/1ns
`include "hpdc_regs.vh"
module test_host_port_display_counters;
   logic        clk, rst, cs_n, rd_n, wr_n, oe, rdy, ben_n, bdir, lsel, stb, pend, mval;
   logic [4:0]  sel;
   logic [7:0]  din, dout, mst, q;
   logic [15:0] led;
   logic [12:0] ev [4];
   int          errors, total_checks, n, k;

   hpdc_host_port dut (.CORE_CLK(clk), .RST(rst), .CLK_EN(1'b1), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
      .REGISTER_SELECT_LINES(sel), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .RDY(rdy),
      .BUF_EN_N(ben_n), .BUF_DIR_RD(bdir), .LED_STATUS(led), .DISP_LATCH_SEL(lsel), .DISP_STROBE(stb),
      .EVT_FCS(ev[0]), .EVT_ALIGN(ev[1]), .EVT_PART(ev[2]), .EVT_OOWC(ev[3]), .MGT_PKT_END(pend),
      .MGT_STATUS(mst), .MGT_STATUS_VALID(mval));
   hpdc_cpu cpu (.clk(clk), .rdy(rdy), .buf_en_n(ben_n), .buf_dir_rd(bdir), .data_out(dout),
      .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sel(sel), .data_in(din));

   task end_of_test;
      if (errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task acc(input logic r, input logic [4:0] a, input logic [7:0] wd);
      cpu.xfer(r, a, wd, q);
      if (cpu.tmo) begin
         errors++;
         $display("ERROR %0t access timeout", $time);
         end_of_test;
      end
   endtask
   task pulse(input int t, input int p);
      @(posedge clk);
      ev[t] <= 13'h0001 << p;
      @(posedge clk);
      ev[t] <= 13'h0000;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      led = 16'ha55a;
      pend = 1'b0;
      for (k = 0; k < 4; k++) ev[k] = 13'h0000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      acc(1'b1, `HPDC_OFF_LOWER_INFO, 8'h00); chk(q, `HPDC_RST_LOWER_INFO);
      acc(1'b1, `HPDC_OFF_MASK2, 8'h00); chk(q, `HPDC_RST_MASK2);
      acc(1'b1, 5'h1e, 8'h00); chk(q, 8'h00);
      // Display bytes follow the targeted latch
      n = 0;
      repeat (40) begin
         @(posedge clk);
         if (stb === 1'b1) begin
            n++;
            chk(dout, lsel ? led[15:8] : led[7:0]);
         end
      end
      chk({7'h0, n != 0}, 8'h01);
      // Status byte after packet end
      @(posedge clk);
      pend <= 1'b1;
      ev[0] <= 13'h0008;
      @(posedge clk);
      pend <= 1'b0;
      ev[0] <= 13'h0000;
      @(posedge clk);
      chk(mst, 8'h01);
      chk({7'h0, mval}, 8'h01);
      // Event latches follow the latching mask and clear on read
      acc(1'b0, `HPDC_OFF_LATCH_MASK, 8'h01);
      acc(1'b1, `HPDC_OFF_LATCH_MASK, 8'h00); chk(q, 8'h01);
      pulse(1, 2);
      pulse(0, 5);
      acc(1'b1, `HPDC_OFF_EVT_FLAGS, 8'h00); chk(q, 8'h01);
      acc(1'b1, `HPDC_OFF_EVT_FLAGS, 8'h00); chk(q, 8'h00);
      // Each event type with reset-on-read
      for (k = 0; k < 4; k++) begin
         acc(1'b0, `HPDC_OFF_MASK2, 8'h40 | (8'h01 << k));
         pulse((k + 1) % 4, k);
         pulse(k, k);
         pulse(k, k);
         acc(1'b1, k[4:0], 8'h00); chk(q, 8'h02);
         acc(1'b1, k[4:0], 8'h00); chk(q, 8'h00);
      end
      acc(1'b0, `HPDC_OFF_MASK2, 8'hc1);
      acc(1'b1, `HPDC_OFF_MASK2, 8'h00); chk(q, 8'hc1);
      @(posedge clk);
      ev[0] <= 13'h1000;
      repeat (300) @(posedge clk);
      ev[0] <= 13'h0000;
      acc(1'b1, `HPDC_OFF_CNT_LAST, 8'h00); chk(q, `HPDC_CNT_FULL);
      acc(1'b1, `HPDC_OFF_CNT_LAST, 8'h00); chk(q, 8'h00);
      acc(1'b0, `HPDC_OFF_CNT_FIRST, 8'h55);
      acc(1'b1, `HPDC_OFF_CNT_FIRST, 8'h00); chk(q, 8'h00);
      // Inhibit display, then slave-only timing
      acc(1'b0, `HPDC_OFF_LOWER_INFO, 8'h01);
      acc(1'b1, `HPDC_OFF_LOWER_INFO, 8'h00); chk(q, 8'h01);
      n = 0;
      repeat (40) begin
         @(posedge clk);
         if (stb === 1'b1) n++;
      end
      chk(n[7:0], 8'h00);
      acc(1'b1, `HPDC_OFF_MASK2, 8'h00); chk({7'h0, cpu.cyc <= 10}, 8'h01);
      chk(q, 8'hc1);
      end_of_test;
   end
endmodule

bind hpdc_host_port hpdc_chk u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
   .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .RDY(RDY), .BUF_EN_N(BUF_EN_N), .BUF_DIR_RD(BUF_DIR_RD),
   .DISP_LATCH_SEL(DISP_LATCH_SEL), .DISP_STROBE(DISP_STROBE), .EVT_FCS(EVT_FCS), .MGT_PKT_END(MGT_PKT_END),
   .MGT_STATUS(MGT_STATUS), .MGT_STATUS_VALID(MGT_STATUS_VALID));
